// *** kel_checker.sv ***
// port-level assertion checker for the keypad event block
`timescale 1ns/100ps
`include "kel_map.svh"
module kel_checker #(
  parameter int unsigned CYCLES_PER_SEC = `KEL_SEC_CYCLES
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // register side
  input wire logic dev_sel_i,
  input wire kel_pkg::kel_byte_t reg_addr_i,
  input wire logic reg_wr_i,
  input wire kel_pkg::kel_byte_t reg_wdata_i,
  input wire logic reg_rd_i,
  input wire kel_pkg::kel_byte_t reg_rdata_o,
  input wire logic port_rd_ack_i,
  // key and pin side
  input wire logic key_valid_i,
  input wire logic key_press_i,
  input wire kel_pkg::kel_code_t key_code_i,
  input wire logic [17:0] gpio_pin_i,
  input wire logic [17:0] gpio_is_input_i,
  // outputs
  input wire logic int_o,
  input wire logic int_oe_o,
  input wire logic osc_keep_on_o
);
  import kel_pkg::*;
  logic wr_ok;
  logic lock_reg;
  kel_byte_t cfg_reg;
  kel_byte_t tmr_reg;
  logic [2:0] held_reg;
  assign wr_ok = dev_sel_i && reg_wr_i;
  // shadow of host settings and held combo keys; lock_reg goes stale after a keyed unlock
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_reg <= 8'h00;
      tmr_reg <= 8'h00;
      lock_reg <= 1'b0;
      held_reg <= 3'b000;
    end else begin
      if (wr_ok && reg_addr_i == `KEL_CFG_ADDR) cfg_reg <= reg_wdata_i;
      if (wr_ok && reg_addr_i == `KEL_LOCK_TMR_ADDR) tmr_reg <= reg_wdata_i;
      if (wr_ok && reg_addr_i == `KEL_LOCK_EC_ADDR) lock_reg <= reg_wdata_i[6];
      if (key_valid_i && key_code_i == `KEL_COMBO_KEY_A) held_reg[0] <= key_press_i;
      if (key_valid_i && key_code_i == `KEL_COMBO_KEY_B) held_reg[1] <= key_press_i;
      if (key_valid_i && key_code_i == `KEL_COMBO_KEY_C) held_reg[2] <= key_press_i;
    end
  end
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);
  open_drain_a: assert property (int_o == 1'b0)
    else $error("interrupt data not low");
  foreign_read_a: assert property (reg_rd_i && !dev_sel_i |=> $stable(reg_rdata_o))
    else $error("unselected read changed read data");
  lock_state_a: assert property ((wr_ok && reg_addr_i == `KEL_LOCK_EC_ADDR && !key_valid_i)
    ##1 (!key_valid_i && !reg_wr_i)
    ##1 (dev_sel_i && reg_rd_i && reg_addr_i == `KEL_LOCK_EC_ADDR && !key_valid_i)
    |=> reg_rdata_o[6] == lock_reg) else $error("lock bit readback wrong");
  key_irq_a: assert property (key_valid_i && key_press_i && key_code_i inside {[1:80]}
    && cfg_reg[0] && !lock_reg && !cfg_reg[4] |-> ##[1:3] int_oe_o)
    else $error("unlocked key press gave no interrupt");
  combo_irq_a: assert property (key_valid_i && key_press_i &&
    ((key_code_i == 7'h01 && held_reg[2:1] == 2'b11) || (key_code_i == 7'h0B && held_reg[0]
    && held_reg[2]) || (key_code_i == 7'h15 && held_reg[1:0] == 2'b11)) |-> ##[1:3] int_oe_o)
    else $error("combination gave no interrupt");
  locked_quiet_a: assert property (key_valid_i && key_press_i && lock_reg && !cfg_reg[2]
    && tmr_reg[7:3] == 5'h00 && held_reg == 3'b000 && !int_oe_o && !$past(key_valid_i)
    && !$past(reg_wr_i) && gpio_is_input_i == 18'h0 |=> !int_oe_o [*3])
    else $error("locked press raised interrupt");
  osc_on_a: assert property (key_valid_i && key_press_i && lock_reg && tmr_reg[7:3] != 5'h00
    && key_code_i inside {[1:80]} |-> ##[1:3] osc_keep_on_o)
    else $error("oscillator not kept on in countdown");
  output_quiet_a: assert property ((!int_oe_o && !key_valid_i && !reg_wr_i && !cfg_reg[4]
    && gpio_is_input_i == 18'h0) [*4] |=> !int_oe_o) else $error("interrupt without cause");
  cover property (lock_reg && key_valid_i && key_press_i);
  cover property ($fell(int_oe_o) && cfg_reg[4]);
  cover property (held_reg == 3'b111);
endmodule
bind kel_top kel_checker #(.CYCLES_PER_SEC(CYCLES_PER_SEC)) i_chk (.*);

// *** kel_evt_fifo.sv ***
// ten-entry shifting key event queue with two overflow policies
`timescale 1ns/100ps
`include "kel_map.svh"
module kel_evt_fifo (
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // fill side
  input wire logic push_i,
  input wire kel_pkg::kel_byte_t data_i,
  input wire logic shift_mode_i,
  // drain side
  input wire logic pop_i,
  output kel_pkg::kel_byte_t head_o,
  output kel_pkg::kel_count_t count_o,
  output logic overflow_o
);
  import kel_pkg::*;
  kel_byte_t mem_reg [`KEL_FIFO_DEPTH];
  kel_byte_t mem_next [`KEL_FIFO_DEPTH];
  kel_count_t cnt_reg;
  kel_count_t cnt_next;
  logic full_after_pop;

  // pop first, then push into what remains
  always_comb begin
    mem_next = mem_reg;
    cnt_next = cnt_reg;
    if (pop_i && cnt_reg != 4'h0) begin
      for (int i = 0; i < `KEL_FIFO_DEPTH - 1; i++) begin
        mem_next[i] = mem_next[i + 1];
      end
      mem_next[`KEL_FIFO_DEPTH - 1] = 8'h00;
      cnt_next = cnt_reg - 4'h1;
    end
    full_after_pop = (cnt_next == 4'(`KEL_FIFO_DEPTH));
    if (push_i) begin
      if (!full_after_pop) begin
        mem_next[cnt_next] = data_i;
        cnt_next = cnt_next + 4'h1;
      end else if (shift_mode_i) begin
        // oldest falls out, newest lands last
        for (int i = 0; i < `KEL_FIFO_DEPTH - 1; i++) begin
          mem_next[i] = mem_next[i + 1];
        end
        mem_next[`KEL_FIFO_DEPTH - 1] = data_i;
      end
      // otherwise the new event is dropped, queue untouched
    end
  end

  assign overflow_o = push_i && full_after_pop;
  assign head_o = mem_reg[0];
  assign count_o = cnt_reg;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_reg <= 4'h0;
      for (int i = 0; i < `KEL_FIFO_DEPTH; i++) begin
        mem_reg[i] <= 8'h00;
      end
    end else begin
      cnt_reg <= cnt_next;
      mem_reg <= mem_next;
    end
  end
endmodule

// *** kel_host_model.sv ***
// host-side view of the open-drain interrupt line
`timescale 1ns/100ps
module kel_host_model (
  // pin from the block
  input wire logic int_i,
  input wire logic int_oe_i,
  // level seen by the host
  output logic int_line_n_o
);
  // released line is pulled up, so the host sees a high
  assign int_line_n_o = int_oe_i ? int_i : 1'b1;
endmodule

// *** kel_map.svh ***
// register offsets, field positions, reset values and timing counts of the keypad event block
`ifndef KEL_MAP_SVH
`define KEL_MAP_SVH
// register offsets
`define KEL_CFG_ADDR 8'h01
`define KEL_INT_STAT_ADDR 8'h02
`define KEL_LOCK_EC_ADDR 8'h03
`define KEL_EVENT_ADDR 8'h04
`define KEL_LOCK_TMR_ADDR 8'h0E
`define KEL_FIRST_UNLOCK_KEY_ADDR 8'h0F
`define KEL_SECOND_UNLOCK_KEY_ADDR 8'h10
// configuration fields
`define KEL_CFG_KEY_IEN 0
`define KEL_CFG_GPI_IEN 1
`define KEL_CFG_LOCK_IEN 2
`define KEL_CFG_OVF_IEN 3
`define KEL_CFG_INT_PULSE 4
`define KEL_CFG_OVF_MODE 5
`define KEL_CFG_RESET 8'h00
// interrupt status fields
`define KEL_ST_KEY 0
`define KEL_ST_GPI 1
`define KEL_ST_LOCK 2
`define KEL_ST_OVF 3
`define KEL_ST_COMBO 4
// lock and event count fields
`define KEL_LOCK_EN_BIT 6
`define KEL_LOCK_WAIT2_BIT 4
// lock timer fields
`define KEL_UNLOCK_TMR_LSB 0
`define KEL_MASK_TMR_LSB 3
// event queue
`define KEL_FIFO_DEPTH 10
`define KEL_GPI_FIRST 7'h61
`define KEL_GPI_LAST 7'h72
`define KEL_KEY_LAST 7'h50
// fixed three-key combination
`define KEL_COMBO_KEY_A 7'h01
`define KEL_COMBO_KEY_B 7'h0B
`define KEL_COMBO_KEY_C 7'h15
// timing
`define KEL_CLK_MHZ 40
`define KEL_PULSE_US 50
`define KEL_PULSE_CYCLES (`KEL_PULSE_US * `KEL_CLK_MHZ)
`define KEL_SEC_CYCLES 40000000
`endif

// *** kel_pkg.sv ***
// types shared by the keypad event block
package kel_pkg;
  typedef logic [7:0] kel_byte_t;
  typedef logic [6:0] kel_code_t;
  typedef logic [3:0] kel_count_t;
  typedef enum logic [2:0] {
    KEL_UNLOCKED = 3'b001,
    KEL_WAIT1 = 3'b010,
    KEL_WAIT2 = 3'b100
  } kel_lock_e;
endpackage

// *** kel_sec_tick.sv ***
// one-second enable pulse divider, restartable
`timescale 1ns/100ps
`include "kel_map.svh"
module kel_sec_tick #(
  parameter int unsigned CYCLES_PER_SEC = `KEL_SEC_CYCLES
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // control
  input wire logic en_i,
  input wire logic restart_i,
  // tick
  output logic tick_o
);
  logic [25:0] cnt_reg;
  logic [25:0] cnt_next;
  logic tick_next;

  // divider held at zero when idle so a new countdown starts a full second
  always_comb begin
    cnt_next = cnt_reg;
    tick_next = 1'b0;
    if (!en_i || restart_i) begin
      cnt_next = 26'h000_0000;
    end else if (cnt_reg == 26'(CYCLES_PER_SEC - 1)) begin
      cnt_next = 26'h000_0000;
      tick_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + 26'h000_0001;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_reg <= 26'h000_0000;
      tick_o <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_o <= tick_next;
    end
  end
endmodule

// *** kel_top.sv ***
// keypad event handling: queue overflow, lock/unlock, mask timer, combo and interrupt pin
`timescale 1ns/100ps
`include "kel_map.svh"
module kel_top #(
  parameter int unsigned CYCLES_PER_SEC = `KEL_SEC_CYCLES
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // register access from the serial slave
  input wire logic dev_sel_i,
  input wire kel_pkg::kel_byte_t reg_addr_i,
  input wire logic reg_wr_i,
  input wire kel_pkg::kel_byte_t reg_wdata_i,
  input wire logic reg_rd_i,
  output kel_pkg::kel_byte_t reg_rdata_o,
  input wire logic port_rd_ack_i,
  // key events from the scanner
  input wire logic key_valid_i,
  input wire logic key_press_i,
  input wire kel_pkg::kel_code_t key_code_i,
  // general purpose pins
  input wire logic [17:0] gpio_pin_i,
  input wire logic [17:0] gpio_is_input_i,
  // interrupt pin and oscillator request
  output logic int_o,
  output logic int_oe_o,
  output logic osc_keep_on_o
);
  import kel_pkg::*;

  localparam logic [10:0] PULSE_CYC = 11'(`KEL_PULSE_CYCLES);

  // valid event table code: matrix key or input-pin code
  function automatic logic code_ok(input kel_code_t c);
    code_ok = (c != 7'h00 && c <= `KEL_KEY_LAST) ||
              (c >= `KEL_GPI_FIRST && c <= `KEL_GPI_LAST);
  endfunction

  kel_byte_t cfg_reg, cfg_next;
  kel_byte_t stat_reg, stat_next;
  kel_byte_t tmr_reg, tmr_next;
  kel_code_t unl1_reg, unl1_next;
  kel_code_t unl2_reg, unl2_next;
  kel_byte_t rdata_next;
  kel_lock_e lock_reg, lock_next;
  logic [4:0] mask_reg, mask_next;
  logic [2:0] unl_cnt_reg, unl_cnt_next;
  logic [2:0] combo_reg, combo_next;
  logic [10:0] pulse_reg, pulse_next;
  logic int_oe_next;
  logic osc_next;
  logic [17:0] pin_meta_reg, pin_sync_reg, port_store_reg, port_store_next;

  logic wr_ok, rd_ok, evt_ok, press_ok;
  logic locked, push, pop, ovf, tick, tick_restart;
  logic port_irq, int_active;
  kel_byte_t head;
  kel_count_t count;

  // only our own transactions reach the registers
  assign wr_ok = reg_wr_i && dev_sel_i;
  assign rd_ok = reg_rd_i && dev_sel_i;
  assign evt_ok = key_valid_i && code_ok(key_code_i);
  assign press_ok = evt_ok && key_press_i;
  assign locked = (lock_reg != KEL_UNLOCKED);
  assign push = evt_ok && !locked;
  assign pop = rd_ok && reg_addr_i == `KEL_EVENT_ADDR;

  kel_evt_fifo u_fifo (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .push_i(push),
    .data_i({key_press_i, key_code_i}),
    .shift_mode_i(cfg_reg[`KEL_CFG_OVF_MODE]),
    .pop_i(pop),
    .head_o(head),
    .count_o(count),
    .overflow_o(ovf)
  );

  kel_sec_tick #(
    .CYCLES_PER_SEC(CYCLES_PER_SEC)
  ) u_tick (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .en_i(osc_keep_on_o),
    .restart_i(tick_restart),
    .tick_o(tick)
  );

  // pins come from outside the clock domain
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_meta_reg <= 18'h0_0000;
      pin_sync_reg <= 18'h0_0000;
    end else begin
      pin_meta_reg <= gpio_pin_i;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // stored input value follows the pins only on our port read ack
  always_comb begin
    port_store_next = port_store_reg;
    if (port_rd_ack_i && dev_sel_i) begin
      port_store_next = pin_sync_reg;
    end
  end

  // mismatch on input pins is the port interrupt; also catches dir switches
  assign port_irq = |((pin_sync_reg ^ port_store_reg) & gpio_is_input_i);

  // configuration registers written by the host
  always_comb begin
    cfg_next = cfg_reg;
    tmr_next = tmr_reg;
    unl1_next = unl1_reg;
    unl2_next = unl2_reg;
    if (wr_ok) begin
      case (reg_addr_i)
        `KEL_CFG_ADDR: cfg_next = reg_wdata_i;
        `KEL_LOCK_TMR_ADDR: tmr_next = reg_wdata_i;
        `KEL_FIRST_UNLOCK_KEY_ADDR: if (code_ok(reg_wdata_i[6:0])) unl1_next = reg_wdata_i[6:0];
        `KEL_SECOND_UNLOCK_KEY_ADDR: if (code_ok(reg_wdata_i[6:0])) unl2_next = reg_wdata_i[6:0];
        default: cfg_next = cfg_reg;
      endcase
    end
  end

  // lock state machine with unlock and mask countdowns
  always_comb begin
    logic [4:0] mask_set;
    logic [2:0] unl_set;
    logic mask_expire;
    mask_set = tmr_reg[7:`KEL_MASK_TMR_LSB];
    unl_set = tmr_reg[`KEL_MASK_TMR_LSB - 1:`KEL_UNLOCK_TMR_LSB];
    mask_expire = tick && mask_reg == 5'h01;
    lock_next = lock_reg;
    mask_next = mask_reg;
    unl_cnt_next = unl_cnt_reg;
    tick_restart = 1'b0;
    if (tick && mask_reg != 5'h00) begin
      mask_next = mask_reg - 5'h01;
    end
    if (tick && unl_cnt_reg != 3'h0) begin
      unl_cnt_next = unl_cnt_reg - 3'h1;
    end
    case (lock_reg)
      KEL_UNLOCKED: begin
        mask_next = 5'h00;
        unl_cnt_next = 3'h0;
        if (wr_ok && reg_addr_i == `KEL_LOCK_EC_ADDR && reg_wdata_i[`KEL_LOCK_EN_BIT]) begin
          lock_next = KEL_WAIT1;
        end
      end
      KEL_WAIT1: begin
        if (press_ok && key_code_i == unl1_reg) begin
          lock_next = KEL_WAIT2;
          unl_cnt_next = unl_set;
          tick_restart = 1'b1;
        end
      end
      KEL_WAIT2: begin
        if (press_ok) begin
          // wrong second key starts the sequence over
          lock_next = (key_code_i == unl2_reg) ? KEL_UNLOCKED : KEL_WAIT1;
        end else if ((tick && unl_cnt_reg == 3'h1) || mask_expire) begin
          lock_next = KEL_WAIT1;
        end
      end
      default: lock_next = KEL_UNLOCKED;
    endcase
    // a locked press outside a mask countdown re-arms the mask
    if (locked && press_ok && mask_set != 5'h00 && mask_reg == 5'h00) begin
      mask_next = mask_set;
      tick_restart = 1'b1;
    end
    if (locked && wr_ok && reg_addr_i == `KEL_LOCK_EC_ADDR &&
        !reg_wdata_i[`KEL_LOCK_EN_BIT]) begin
      lock_next = KEL_UNLOCKED;
    end
  end

  // seconds divider runs only while a countdown is live
  assign osc_next = (mask_next != 5'h00) || (unl_cnt_next != 3'h0);

  // combo key tracking, independent of the lock
  always_comb begin
    combo_next = combo_reg;
    if (evt_ok) begin
      if (key_code_i == `KEL_COMBO_KEY_A) combo_next[0] = key_press_i;
      if (key_code_i == `KEL_COMBO_KEY_B) combo_next[1] = key_press_i;
      if (key_code_i == `KEL_COMBO_KEY_C) combo_next[2] = key_press_i;
    end
  end

  // sticky status: write 1 clears, a set in the same cycle wins
  always_comb begin
    kel_byte_t set_bits;
    kel_byte_t clr_bits;
    set_bits = 8'h00;
    clr_bits = 8'h00;
    if (push) begin
      set_bits[(key_code_i >= `KEL_GPI_FIRST) ? `KEL_ST_GPI : `KEL_ST_KEY] = 1'b1;
    end
    if (locked && press_ok && tmr_reg[7:`KEL_MASK_TMR_LSB] != 5'h00 && mask_reg == 5'h00) begin
      set_bits[`KEL_ST_KEY] = 1'b1;
    end
    if (lock_reg == KEL_WAIT2 && press_ok && key_code_i == unl2_reg) begin
      set_bits[`KEL_ST_LOCK] = 1'b1;
    end
    if (ovf) begin
      set_bits[`KEL_ST_OVF] = 1'b1;
    end
    if (combo_next == 3'b111 && combo_reg != 3'b111) begin
      set_bits[`KEL_ST_COMBO] = 1'b1;
    end
    if (wr_ok && reg_addr_i == `KEL_INT_STAT_ADDR) begin
      clr_bits = reg_wdata_i;
      if (count != 4'h0) begin
        // event flags cannot clear while the queue still holds events
        clr_bits[`KEL_ST_KEY] = 1'b0;
        clr_bits[`KEL_ST_GPI] = 1'b0;
      end
    end
    stat_next = (stat_reg & ~clr_bits) | set_bits;
    stat_next[7:5] = 3'h0;
  end

  // interrupt pin drive with optional release pulse
  always_comb begin
    pulse_next = pulse_reg;
    if (pulse_reg != 11'h000) begin
      pulse_next = pulse_reg - 11'h001;
    end
    if (cfg_reg[`KEL_CFG_INT_PULSE] && wr_ok && reg_addr_i == `KEL_INT_STAT_ADDR &&
        reg_wdata_i != 8'h00 && int_oe_o && count != 4'h0) begin
      pulse_next = PULSE_CYC;
    end
  end

  assign int_active = (stat_reg[`KEL_ST_KEY] && cfg_reg[`KEL_CFG_KEY_IEN]) ||
                      (stat_reg[`KEL_ST_GPI] && cfg_reg[`KEL_CFG_GPI_IEN]) ||
                      (stat_reg[`KEL_ST_LOCK] && cfg_reg[`KEL_CFG_LOCK_IEN]) ||
                      (stat_reg[`KEL_ST_OVF] && cfg_reg[`KEL_CFG_OVF_IEN]) ||
                      stat_reg[`KEL_ST_COMBO] || port_irq;
  assign int_oe_next = int_active && (pulse_next == 11'h000);

  // registered read data; the event head read also pops
  always_comb begin
    rdata_next = reg_rdata_o;
    if (rd_ok) begin
      case (reg_addr_i)
        `KEL_CFG_ADDR: rdata_next = cfg_reg;
        `KEL_INT_STAT_ADDR: rdata_next = stat_reg;
        `KEL_LOCK_EC_ADDR: rdata_next = {1'b0, locked, 1'b0, lock_reg == KEL_WAIT2, count};
        `KEL_EVENT_ADDR: rdata_next = (count != 4'h0) ? head : 8'h00;
        `KEL_LOCK_TMR_ADDR: rdata_next = tmr_reg;
        `KEL_FIRST_UNLOCK_KEY_ADDR: rdata_next = {1'b0, unl1_reg};
        `KEL_SECOND_UNLOCK_KEY_ADDR: rdata_next = {1'b0, unl2_reg};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // state registers other than the pin synchronizer
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_reg <= `KEL_CFG_RESET;
      stat_reg <= 8'h00;
      tmr_reg <= 8'h00;
      unl1_reg <= 7'h00;
      unl2_reg <= 7'h00;
      lock_reg <= KEL_UNLOCKED;
      mask_reg <= 5'h00;
      unl_cnt_reg <= 3'h0;
      combo_reg <= 3'h0;
      pulse_reg <= 11'h000;
      port_store_reg <= 18'h0_0000;
      reg_rdata_o <= 8'h00;
      int_o <= 1'b0;
      int_oe_o <= 1'b0;
      osc_keep_on_o <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      stat_reg <= stat_next;
      tmr_reg <= tmr_next;
      unl1_reg <= unl1_next;
      unl2_reg <= unl2_next;
      lock_reg <= lock_next;
      mask_reg <= mask_next;
      unl_cnt_reg <= unl_cnt_next;
      combo_reg <= combo_next;
      pulse_reg <= pulse_next;
      port_store_reg <= port_store_next;
      reg_rdata_o <= rdata_next;
      int_o <= 1'b0;
      int_oe_o <= int_oe_next;
      osc_keep_on_o <= osc_next;
    end
  end
endmodule

// *** tb_kel_top.sv ***
// self-checking bench for the keypad event block
`timescale 1ns/100ps
`include "kel_map.svh"
module tb_kel_top;
  import kel_pkg::*;
  localparam int unsigned SEC = 20;
  localparam kel_byte_t CF = 8'h01, ST = 8'h02, LK = 8'h03, EV = 8'h04, TM = 8'h0E;
  logic clock_i, nrst_i, dev_sel_i, reg_wr_i, reg_rd_i, port_rd_ack_i;
  logic key_valid_i, key_press_i, int_o, int_oe_o, osc_keep_on_o, line_n;
  kel_byte_t reg_addr_i, reg_wdata_i, reg_rdata_o;
  kel_code_t key_code_i;
  logic [17:0] gpio_pin_i, gpio_is_input_i;
  int failures, checked, cycles, i;
  kel_top #(.CYCLES_PER_SEC(SEC)) i_dut (.*);
  kel_host_model i_host (.int_i(int_o), .int_oe_i(int_oe_o), .int_line_n_o(line_n));
  // free-running clock
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  // hang guard, well above the expected few thousand cycles
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d, failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input kel_byte_t got, input kel_byte_t exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input kel_byte_t a, input kel_byte_t d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
    // one idle edge so a following call never re-raises the strobe in this step
    @(posedge clock_i);
  endtask
  task automatic rd(input kel_byte_t a, input kel_byte_t exp);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, exp);
    @(posedge clock_i);
  endtask
  task automatic key(input logic p, input kel_code_t c);
    key_valid_i <= 1'b1;
    key_press_i <= p;
    key_code_i <= c;
    @(posedge clock_i);
    key_valid_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  // line level is looked at once the edge's updates have landed
  task automatic lchk(input logic e);
    #1 chk({7'h0, line_n}, {7'h0, e});
    @(posedge clock_i);
  endtask
  initial begin
    {nrst_i, reg_wr_i, reg_rd_i, port_rd_ack_i, key_valid_i, key_press_i} = '0;
    dev_sel_i = 1'b1;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    key_code_i = 7'h00;
    gpio_pin_i = 18'h0_0000;
    gpio_is_input_i = 18'h0_0000;
    {failures, checked} = '0;
    cyc(16);
    nrst_i <= 1'b1;
    @(posedge clock_i);
    rd(CF, 8'h00);
    rd(8'h05, 8'h00);
    wr(TM, 8'hA5);
    rd(TM, 8'hA5);
    // unselected traffic: write ignored, read data left standing
    dev_sel_i <= 1'b0;
    wr(CF, 8'h3F);
    rd(CF, 8'hA5);
    dev_sel_i <= 1'b1;
    rd(CF, 8'h00);
    // event byte format and queue drain
    wr(CF, 8'h01);
    key(1'b1, 7'd32);
    cyc(2);
    lchk(1'b0);
    key(1'b0, 7'd32);
    rd(LK, 8'h02);
    rd(EV, 8'hA0);
    rd(LK, 8'h01);
    rd(EV, 8'h20);
    wr(ST, 8'hFF);
    cyc(2);
    lchk(1'b1);
    // overflow, drop-new then shift-out policy
    wr(CF, 8'h08);
    for (i = 1; i <= 11; i++) key(1'b1, 7'(40 + i));
    rd(ST, 8'h09);
    lchk(1'b0);
    for (i = 1; i <= 10; i++) rd(EV, 8'h80 + 8'(40 + i));
    wr(ST, 8'hFF);
    wr(CF, 8'h28);
    for (i = 1; i <= 11; i++) key(1'b1, 7'(40 + i));
    rd(ST, 8'h09);
    for (i = 2; i <= 11; i++) rd(EV, 8'h80 + 8'(40 + i));
    rd(LK, 8'h00);
    wr(ST, 8'hFF);
    // lock and two-key unlock, mask off
    wr(CF, 8'h00);
    wr(TM, 8'h00);
    wr(8'h0F, 8'h05);
    wr(8'h10, 8'h61);
    wr(8'h0F, 8'h55);
    rd(8'h0F, 8'h05);
    wr(LK, 8'h40);
    rd(LK, 8'h40);
    key(1'b1, 7'd7);
    rd(LK, 8'h40);
    key(1'b1, 7'd5);
    rd(LK, 8'h50);
    key(1'b1, 7'd7);
    rd(LK, 8'h40);
    key(1'b1, 7'd5);
    key(1'b1, 7'h61);
    rd(ST, 8'h04);
    rd(LK, 8'h00);
    wr(ST, 8'hFF);
    wr(LK, 8'h40);
    wr(LK, 8'h00);
    rd(LK, 8'h00);
    key(1'b1, 7'd8);
    rd(LK, 8'h01);
    rd(EV, 8'h88);
    // input-pin code is queued like a key and raises its own flag
    key(1'b1, 7'h61);
    rd(ST, 8'h03);
    rd(EV, 8'hE1);
    // second unlock key too late: unlock timer sends the sequence back
    wr(TM, 8'h01);
    wr(LK, 8'h40);
    key(1'b1, 7'd5);
    rd(LK, 8'h50);
    cyc(SEC + 5);
    rd(LK, 8'h40);
    wr(LK, 8'h00);
    // mask countdown while locked
    wr(CF, 8'h01);
    wr(ST, 8'hFF);
    wr(TM, 8'h08);
    wr(LK, 8'h40);
    key(1'b1, 7'd9);
    cyc(2);
    lchk(1'b0);
    #1 chk({7'h0, osc_keep_on_o}, 8'h01);
    @(posedge clock_i);
    wr(ST, 8'h01);
    key(1'b1, 7'd9);
    cyc(3);
    lchk(1'b1);
    cyc(SEC + 5);
    key(1'b1, 7'd5);
    cyc(2);
    lchk(1'b0);
    rd(LK, 8'h50);
    cyc(SEC + 5);
    rd(LK, 8'h40);
    wr(ST, 8'h01);
    wr(LK, 8'h00);
    // interrupt release pulse while events pend, then steady level
    wr(CF, 8'h11);
    for (i = 0; i < 3; i++) key(1'b1, 7'd60);
    cyc(2);
    lchk(1'b0);
    wr(ST, 8'h01);
    cyc(2);
    lchk(1'b1);
    cyc(`KEL_PULSE_CYCLES - 20);
    lchk(1'b1);
    cyc(30);
    lchk(1'b0);
    wr(CF, 8'h01);
    wr(ST, 8'h01);
    cyc(2);
    lchk(1'b0);
    for (i = 0; i < 3; i++) rd(EV, 8'hBC);
    wr(ST, 8'hFF);
    cyc(2);
    lchk(1'b1);
    // fixed three-key combination, then a reset in mid-run
    wr(CF, 8'h00);
    key(1'b1, 7'd1);
    key(1'b1, 7'd11);
    key(1'b1, 7'd21);
    cyc(2);
    lchk(1'b0);
    rd(ST, 8'h11);
    nrst_i <= 1'b0;
    cyc(2);
    nrst_i <= 1'b1;
    @(posedge clock_i);
    rd(ST, 8'h00);
    // port pins: output mode silent, input mode edges and read clear
    gpio_pin_i <= 18'h0_0001;
    cyc(6);
    lchk(1'b1);
    gpio_is_input_i <= 18'h0_0001;
    cyc(5);
    lchk(1'b0);
    port_rd_ack_i <= 1'b1;
    @(posedge clock_i);
    port_rd_ack_i <= 1'b0;
    cyc(3);
    lchk(1'b1);
    gpio_pin_i <= 18'h0_0000;
    cyc(5);
    lchk(1'b0);
    gpio_pin_i <= 18'h0_0001;
    cyc(5);
    lchk(1'b1);
    finish_test();
  end
endmodule
